//--- general_purpose_io_port_test.sv
// Self-checking bench for the general purpose I/O port
`timescale 1ns/1ps
module general_purpose_io_port_test;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, vfetch = 1'b0, hready, irq;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [7:0]  claim = 8'h00, aen = 8'h00, adat = 8'h00, aod = 8'h00, ext_val = 8'hff;
  logic [7:0]  pin_lvl, pin_o, pin_oe, pull, dat, dir, opt, rd, c, m;
  logic [7:0]  ra [4] = '{gpio_port_pkg::DIR_OFS, gpio_port_pkg::OPT_OFS,
                          gpio_port_pkg::IEN_OFS, 8'h20};
  logic [7:0]  rv [4] = '{gpio_port_pkg::DIR_RST, gpio_port_pkg::OPT_RST,
                          gpio_port_pkg::IEN_RST, 8'h00};
  int          err_count = 0, n_tests = 0;
  gpio_port DUT (.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(),
    .PIN_IN(pin_lvl), .PIN_OUT(pin_o), .PIN_OE_OUT(pin_oe), .PULLUP_EN_OUT(pull),
    .ALT_CLAIM_IN(claim), .ALT_OUT_EN_IN(aen), .ALT_DATA_IN(adat), .ALT_OPEN_DRAIN_IN(aod),
    .ALT_PIN_LEVEL_OUT(), .VECTOR_FETCH_IN(vfetch), .EXT_IRQ_OUT(irq));
  pin_partner pins (.clk_in(clk), .drive_in(pin_o), .oe_in(pin_oe), .pullup_in(pull),
    .ext_en_in(8'hff), .ext_val_in(ext_val), .level_out(pin_lvl));
  // ===========================================================================
  // Tasks and expectations
  function automatic logic [7:0] exp_oe();
    return (m & ~(aod & adat)) | (~m & dir & (opt | ~dat));
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hsel <= 1'b1;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task automatic wait_irq();
    repeat (12) if (irq !== 1'b1) @(posedge clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ===========================================================================
  // Clock, watchdog and tests
  initial forever #2.5 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(28));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b1, 8'h20, 32'hff);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      check("reset value", rd, rv[i]);
    end
    $display("test reset values done");
    for (int k = 0; k < 16; k++) begin
      c = k < 2 ? 8'h00 : 8'($urandom);
      m = c & 8'($urandom);
      dat = k < 2 ? {8{k[0]}} : 8'($urandom);
      dir = k < 2 ? 8'hff : 8'($urandom) & ~(c & ~m);
      opt = k < 2 ? ~dat : 8'($urandom) & ~c;
      claim <= c;
      aen <= m;
      adat <= 8'($urandom);
      aod <= 8'($urandom);
      ext_val <= 8'($urandom);
      bus(1'b1, gpio_port_pkg::DATA_OFS, {24'h0, dat});
      bus(1'b1, gpio_port_pkg::DIR_OFS, {24'h0, dir});
      bus(1'b1, gpio_port_pkg::OPT_OFS, {24'h0, opt});
      repeat (3) @(posedge clk);
      bus(1'b0, gpio_port_pkg::DATA_OFS, 32'h0);
      check("read data", rd & ~m, ((dir & dat) | (~dir & ext_val)) & ~m);
      check("output enable", pin_oe, exp_oe());
      check("pin drive", pin_o & exp_oe() & ~m, dat & exp_oe() & ~m);
      check("pull-up", pull, ~dir & opt);
    end
    $display("test pin modes done");
    claim <= 8'h00;
    ext_val <= 8'hfd;
    bus(1'b1, gpio_port_pkg::DIR_OFS, 32'h0);
    bus(1'b1, gpio_port_pkg::OPT_OFS, 32'h3);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, gpio_port_pkg::SENS_OFS, 32'(s));
      bus(1'b0, gpio_port_pkg::SENS_OFS, 32'h0);
      check("sensitivity", rd, 8'(s));
    end
    ext_val <= 8'hfc;
    repeat (6) @(posedge clk);
    ext_val <= 8'hfd;
    repeat (6) @(posedge clk);
    check("masked request", irq, 8'h0);
    ext_val <= 8'hff;
    wait_irq();
    check("raised request", irq, 8'h1);
    vfetch <= 1'b1;
    @(posedge clk);
    vfetch <= 1'b0;
    @(posedge clk);
    check("fetched request", irq, 8'h0);
    ext_val <= 8'hfe;
    wait_irq();
    bus(1'b1, gpio_port_pkg::SENS_OFS, 32'(gpio_port_pkg::SENS_RISE));
    @(posedge clk);
    check("discarded request", irq, 8'h0);
    $display("test interrupts done");
    conclude();
  end
endmodule

//--- gpio_port.sv
// Eight-bit general purpose I/O port with AHB-Lite register access
// ===========================================================================
// Overview of operation
// - Eight pins, each input or output
// - Data latch, direction and option registers
// - Register bit X serves pin X
// - Direction bit 0 makes an input
// - Input bit reads the pin level
// - Data writes always update the latch
// - Option bit picks input mode
// - Interrupt pins raise one shared request
// - Sensitivity programmable in separate register
// - Shared-vector pins combined by NAND
// - Request latch clears on vector fetch
// - Sensitivity change discards pending request
// - Direction bit 1 drives latch out
// - Output bit reads the latch
// - Option bit picks push-pull or open-drain
// - Zero drives low; one high or floats
// - Peripheral claim overrides port pull-up and interrupt settings
// - Peripheral output forces output, its drive
// - Peripheral input pin stays readable
// - Output option 0 open-drain, 1 push-pull
// - Input option 0 floating, 1 pull-up
// - All registers reset to zero except interrupt enable, which resets to all ones
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module gpio_port (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CE_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic [7:0]  PIN_IN,
  output logic      [7:0]  PIN_OUT,
  output logic      [7:0]  PIN_OE_OUT,
  output logic      [7:0]  PULLUP_EN_OUT,
  input  wire logic [7:0]  ALT_CLAIM_IN,
  input  wire logic [7:0]  ALT_OUT_EN_IN,
  input  wire logic [7:0]  ALT_DATA_IN,
  input  wire logic [7:0]  ALT_OPEN_DRAIN_IN,
  output logic      [7:0]  ALT_PIN_LEVEL_OUT,
  input  wire logic        VECTOR_FETCH_IN,
  output logic             EXT_IRQ_OUT
);

  // ===========================================================================
  // State
  typedef struct packed {
    gpio_port_pkg::bus_state_t bus;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] opt;
    logic [1:0] sens;
    logic [7:0] ien;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic       src_prev;
    logic       pend;
    logic [7:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  localparam state_t STATE_RST = '{
    bus:      gpio_port_pkg::BUS_IDLE,
    addr:     8'h00,
    data:     gpio_port_pkg::DATA_RST,
    dir:      gpio_port_pkg::DIR_RST,
    opt:      gpio_port_pkg::OPT_RST,
    sens:     gpio_port_pkg::SENS_RST,
    ien:      gpio_port_pkg::IEN_RST,
    sync1:    8'h00,
    sync2:    8'h00,
    src_prev: 1'b1,
    pend:     1'b0,
    rdata:    8'h00
  };

  // ===========================================================================
  // Helpers
  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input logic [7:0] dread,
                                          input state_t     st);
    case (addr)
      gpio_port_pkg::DATA_OFS: read_mux = dread;
      gpio_port_pkg::DIR_OFS:  read_mux = st.dir;
      gpio_port_pkg::OPT_OFS:  read_mux = st.opt;
      gpio_port_pkg::SENS_OFS: read_mux = {6'h00, st.sens};
      gpio_port_pkg::IEN_OFS:  read_mux = st.ien;
      gpio_port_pkg::PEND_OFS: read_mux = {7'h00, st.pend};
      default:                 read_mux = 8'h00;
    endcase
  endfunction

  // ===========================================================================
  // Pin logic
  logic [7:0] irq_pins;
  logic       irq_src;
  logic       irq_event;
  logic [7:0] data_read;
  logic [7:0] drive_val;
  logic [7:0] drive_od;
  logic [7:0] drive_en;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ALT_CLAIM_IN[i] && ALT_OUT_EN_IN[i]) begin
        drive_en[i]  = 1'b1;
        drive_val[i] = ALT_DATA_IN[i];
        drive_od[i]  = ALT_OPEN_DRAIN_IN[i];
      end else begin
        drive_en[i]  = s_q.dir[i];
        drive_val[i] = s_q.data[i];
        drive_od[i]  = ~s_q.opt[i];
      end
      PIN_OUT[i]    = 1'b0;
      PIN_OE_OUT[i] = 1'b0;
      if (drive_en[i]) begin
        PIN_OUT[i]    = drive_val[i];
        PIN_OE_OUT[i] = ~drive_val[i] | ~drive_od[i];
      end
      PULLUP_EN_OUT[i] = ~drive_en[i] & s_q.opt[i] & ~ALT_CLAIM_IN[i];
      irq_pins[i] = ~s_q.dir[i] & s_q.opt[i] & s_q.ien[i] & ~ALT_CLAIM_IN[i];
    end
    // Input bits show the synchronised pin, output bits the latch
    data_read = (s_q.dir & s_q.data) | (~s_q.dir & s_q.sync2);
    irq_src = ~(&(s_q.sync2 | ~irq_pins));
    if (irq_pins == 8'h00) begin
      irq_src = 1'b0;
    end
  end

  assign ALT_PIN_LEVEL_OUT = s_q.sync2;

  always_comb begin
    case (s_q.sens)
      gpio_port_pkg::SENS_RISE: irq_event = irq_src & ~s_q.src_prev;
      gpio_port_pkg::SENS_FALL: irq_event = ~irq_src & s_q.src_prev;
      gpio_port_pkg::SENS_BOTH: irq_event = irq_src ^ s_q.src_prev;
      default:                  irq_event = ~irq_src;
    endcase
  end

  // ===========================================================================
  // Next state
  logic addr_ok;
  logic wr_data;
  logic wr_sens;

  always_comb begin
    s_d = s_q;
    addr_ok = HSEL_IN & HREADY_IN & HTRANS_IN[1];
    wr_data = 1'b0;
    wr_sens = 1'b0;
    s_d.sync1 = PIN_IN;
    s_d.sync2 = s_q.sync1;
    s_d.src_prev = irq_src;
    // Data phase of previous transfer
    case (s_q.bus)
      gpio_port_pkg::BUS_WRITE: begin
        case (s_q.addr)
          gpio_port_pkg::DATA_OFS: begin
            s_d.data = HWDATA_IN[7:0];
            wr_data = 1'b1;
          end
          gpio_port_pkg::DIR_OFS: s_d.dir = HWDATA_IN[7:0];
          gpio_port_pkg::OPT_OFS: s_d.opt = HWDATA_IN[7:0];
          gpio_port_pkg::SENS_OFS: begin
            s_d.sens = HWDATA_IN[gpio_port_pkg::SENS_LSB +: 2];
            wr_sens = 1'b1;
          end
          gpio_port_pkg::IEN_OFS: s_d.ien = HWDATA_IN[7:0];
          default: ;
        endcase
      end
      default: ;
    endcase
    // Address phase
    s_d.bus = gpio_port_pkg::BUS_IDLE;
    if (addr_ok) begin
      s_d.addr = {HADDR_IN[7:2], 2'b00};
      s_d.bus  = HWRITE_IN ? gpio_port_pkg::BUS_WRITE : gpio_port_pkg::BUS_READ;
      s_d.rdata = read_mux({HADDR_IN[7:2], 2'b00}, data_read, s_q);
    end
    // Request latch: event sets, fetch or sensitivity write clears
    if (VECTOR_FETCH_IN) begin
      s_d.pend = 1'b0;
    end
    if (wr_sens) begin
      s_d.pend = 1'b0;
    end
    if (irq_event && (irq_pins != 8'h00) && !wr_sens) begin
      s_d.pend = 1'b1;
    end
  end

  // ===========================================================================
  // Registers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s_q <= STATE_RST;
    end else if (CE_IN) begin
      s_q <= s_d;
    end
  end

  // ===========================================================================
  // Outputs
  assign HRDATA_OUT    = {24'h000000, s_q.rdata};
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  assign EXT_IRQ_OUT   = s_q.pend;

endmodule

//--- gpio_port_asserts.sv
// Concurrent checks on the port pins and register bus
`timescale 1ns/1ps
module gpio_port_asserts (
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        CE_IN,
  input wire logic [7:0]  PIN_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic [7:0]  PIN_OUT,
  input wire logic [7:0]  PIN_OE_OUT,
  input wire logic [7:0]  PULLUP_EN_OUT,
  input wire logic [7:0]  ALT_CLAIM_IN,
  input wire logic [7:0]  ALT_OUT_EN_IN,
  input wire logic [7:0]  ALT_DATA_IN,
  input wire logic [7:0]  ALT_OPEN_DRAIN_IN,
  input wire logic [7:0]  ALT_PIN_LEVEL_OUT,
  input wire logic        EXT_IRQ_OUT
);
  wire [7:0] drv = ALT_CLAIM_IN & ALT_OUT_EN_IN;
  default clocking dc @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // ===========================================================================
  // Properties
  sequence s_synced;
    !$past(RST_IN, 2) && !$past(RST_IN) && $past(CE_IN, 2) && $past(CE_IN);
  endsequence
  property p_bus; HREADYOUT_OUT && !HRESP_OUT; endproperty
  property p_upper; HRDATA_OUT[31:8] == 24'h0; endproperty
  property p_sync; s_synced |-> ALT_PIN_LEVEL_OUT == $past(PIN_IN, 2); endproperty
  property p_alt_oe; (PIN_OE_OUT & drv) == (drv & ~(ALT_OPEN_DRAIN_IN & ALT_DATA_IN)); endproperty
  property p_alt_val; (PIN_OUT & PIN_OE_OUT & drv) == (ALT_DATA_IN & PIN_OE_OUT & drv); endproperty
  property p_claim_pull; (PULLUP_EN_OUT & ALT_CLAIM_IN) == 8'h00; endproperty
  property p_out_pull; (PULLUP_EN_OUT & PIN_OE_OUT) == 8'h00; endproperty
  property p_reset;
    $fell(RST_IN) |-> !EXT_IRQ_OUT && HRDATA_OUT == 32'h0 && (PIN_OE_OUT & ~drv) == 8'h00
      && PULLUP_EN_OUT == 8'h00;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready or okay");
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  a_sync: assert property (p_sync) else $error("pin level not two stages late");
  a_alt_oe: assert property (p_alt_oe) else $error("peripheral drive enable wrong");
  a_alt_val: assert property (p_alt_val) else $error("peripheral drive value wrong");
  a_claim_pull: assert property (p_claim_pull) else $error("pull-up on claimed pin");
  a_out_pull: assert property (p_out_pull) else $error("pull-up on driven pin");
  a_reset: assert property (p_reset) else $error("state after reset wrong");
endmodule
bind gpio_port gpio_port_asserts chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN),
  .PIN_IN(PIN_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT),
  .HRESP_OUT(HRESP_OUT), .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT),
  .PULLUP_EN_OUT(PULLUP_EN_OUT), .ALT_CLAIM_IN(ALT_CLAIM_IN), .ALT_OUT_EN_IN(ALT_OUT_EN_IN),
  .ALT_DATA_IN(ALT_DATA_IN), .ALT_OPEN_DRAIN_IN(ALT_OPEN_DRAIN_IN),
  .ALT_PIN_LEVEL_OUT(ALT_PIN_LEVEL_OUT), .EXT_IRQ_OUT(EXT_IRQ_OUT));

//--- gpio_port_pkg.sv
// Package with register map, reset values and modes of the general purpose I/O port
package gpio_port_pkg;
  // ===========================================================================
  // Register byte addresses
  localparam logic [7:0] DATA_OFS  = 8'h00;
  localparam logic [7:0] DIR_OFS   = 8'h04;
  localparam logic [7:0] OPT_OFS   = 8'h08;
  localparam logic [7:0] SENS_OFS  = 8'h0c;
  localparam logic [7:0] IEN_OFS   = 8'h10;
  localparam logic [7:0] PEND_OFS  = 8'h14;
  // ===========================================================================
  // Reset values
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [7:0] DIR_RST   = 8'h00;
  localparam logic [7:0] OPT_RST   = 8'h00;
  localparam logic [1:0] SENS_RST  = 2'h0;
  localparam logic [7:0] IEN_RST   = 8'hff;
  // ===========================================================================
  // Sensitivity field position and encodings
  localparam int SENS_LSB = 0;
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE     = 2'h1;
  localparam logic [1:0] SENS_FALL     = 2'h2;
  localparam logic [1:0] SENS_BOTH     = 2'h3;
  // ===========================================================================
  // Bus state
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b11
  } bus_state_t;
endpackage

//--- pin_partner.sv
// Model of the package pins and the board drivers around the port
`timescale 1ns/1ps
module pin_partner (
  input  wire logic       clk_in,
  input  wire logic [7:0] drive_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] pullup_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_val_in,
  output logic      [7:0] level_out
);
  logic [7:0] wander_q = 8'h55;
  always @(posedge clk_in) wander_q <= ~wander_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_in[i]) level_out[i] = drive_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pullup_in[i]) level_out[i] = 1'b1;
      else level_out[i] = wander_q[i];
    end
  end
endmodule
